// *** logic/cfi_leaves.sv ***
// extended identification leaves 8000_0007 to 8000_0019, answered one cycle after request
//
// How it works
// - power edx bit 8: constant timestamp rate
// - power edx bit 7: hardware perf-state control
// - power edx bit 6: fine multiplier steps
// - power edx bits 5,4 from product configuration
// - power edx bits 3 and 0 read one
// - power edx bits 2 and 1 read zero
// - linear address bits 30h long, else 20h
// - physical address bits read 30h
// - core number bit width reads 2h
// - enabled core count minus one, after disables
// - virtualization leaf zero when not capable
// - address space id count reads 40h
// - next pointer save follows silicon revision
// - lock, branch record, nested paging read one
// - gig page l1 data tlb Fh, 48
// - gig page l2 data tlb 6,16 later only
// - gig page l2 instruction tlb fields zero
// - associativity codes use shared four-bit encoding
`timescale 1ns/100ps
`default_nettype none
`include "cfi_cfg.svh"

module cfi_leaves
	import cfi_pkg::*;
#(
	parameter logic [7:0] VIRT_REVISION = 8'h05 // arbitrary revision code
) (
	input  wire logic          sys_clk,
	input  wire logic          nrst,
	input  wire logic          req_valid,
	input  wire logic [31:0]   req_func,
	input  wire cfi_strap_type strap,
	output logic               rsp_valid,
	output cfi_words_type      rsp_words
);

	// popcount of enabled cores, minus one, saturating at zero
	function automatic logic [7:0] cfi_core_count(input logic [3:0] disable_mask);
		logic [7:0] n;
		n = 8'h00;
		for (int i = 0; i < `CFI_CORE_TOTAL; i++) begin
			n = n + {7'h00, ~disable_mask[i]};
		end
		cfi_core_count = (n == 8'h00) ? 8'h00 : n - 8'h01;
	endfunction

	// one associativity/entries field of a tlb word
	function automatic logic [15:0] cfi_tlb_field(input logic [3:0] assoc, input logic [11:0] ent);
		cfi_tlb_field = {assoc, ent};
	endfunction

	// leaf decode
	wire hit_pwr  = (req_func == `CFI_LEAF_PWR);
	wire hit_addr = (req_func == `CFI_LEAF_ADDR);
	wire hit_virt = (req_func == `CFI_LEAF_VIRT);
	wire hit_gig  = (req_func == `CFI_LEAF_GIG);

	// power-management edx word, upper bits reserved
	wire [31:0] pwr_edx;
	assign pwr_edx[31:9]                  = 23'h000000;
	assign pwr_edx[`CFI_PWR_TSC_BIT]      = 1'b1;
	assign pwr_edx[`CFI_PWR_HWPS_BIT]     = 1'b1;
	assign pwr_edx[`CFI_PWR_STEP_BIT]     = 1'b1;
	assign pwr_edx[`CFI_PWR_STC_BIT]      = strap.software_thermal_control;
	assign pwr_edx[`CFI_PWR_HTC_BIT]      = strap.hardware_thermal_control;
	assign pwr_edx[`CFI_PWR_TTP_BIT]      = 1'b1;
	assign pwr_edx[`CFI_PWR_VID_BIT]      = 1'b0;
	assign pwr_edx[`CFI_PWR_FID_BIT]      = 1'b0;
	assign pwr_edx[`CFI_PWR_TS_BIT]       = 1'b1;

	// address-size words
	wire [7:0]  lin_bits = strap.long_mode_capable ? `CFI_LIN_BITS_LONG
		: `CFI_LIN_BITS_LEGACY;
	wire [31:0] addr_eax = {16'h0000, lin_bits, `CFI_PHYS_BITS};
	wire [7:0]  core_nc  = cfi_core_count(strap.core_disable_mask);
	wire [31:0] addr_ecx = {16'h0000, `CFI_CORE_ID_BITS, 4'h0, core_nc};

	// virtualization words, only when capable
	wire [31:0] virt_eax = {24'h000000, VIRT_REVISION};
	wire [31:0] virt_ebx = `CFI_ASID_COUNT;
	wire [31:0] virt_edx;
	assign virt_edx[31:4]                 = 28'h0000000;
	assign virt_edx[`CFI_VIRT_NRIP_BIT]   = strap.later_revision;
	assign virt_edx[`CFI_VIRT_LOCK_BIT]   = 1'b1;
	assign virt_edx[`CFI_VIRT_LBR_BIT]    = 1'b1;
	assign virt_edx[`CFI_VIRT_NP_BIT]     = 1'b1;
	wire        virt_on  = strap.virtualization_capable;

	// gig-page tlb words; codes follow the shared associativity encoding
	wire [15:0] l1d_fld  = cfi_tlb_field(`CFI_ASSOC_FULL, `CFI_L1D_GIG_ENTRIES);
	wire [15:0] l1i_fld  = cfi_tlb_field(`CFI_ASSOC_OFF, `CFI_NO_ENTRIES);
	wire [15:0] l2d_fld  = strap.later_revision
		? cfi_tlb_field(`CFI_ASSOC_8WAY, `CFI_L2D_GIG_ENTRIES)
		: cfi_tlb_field(`CFI_ASSOC_OFF, `CFI_NO_ENTRIES);
	wire [15:0] l2i_fld  = cfi_tlb_field(`CFI_ASSOC_OFF, `CFI_NO_ENTRIES);
	wire [31:0] gig_eax  = {l1d_fld, l1i_fld};
	wire [31:0] gig_ebx  = {l2d_fld, l2i_fld};

	// result selection; every other leaf and reserved word is zero
	cfi_words_type next_words;
	always_comb begin
		next_words = '0;
		if (hit_pwr) begin
			next_words.edx = pwr_edx;
		end
		if (hit_addr) begin
			next_words.eax = addr_eax;
			next_words.ecx = addr_ecx;
		end
		if (hit_virt && virt_on) begin
			next_words.eax = virt_eax;
			next_words.ebx = virt_ebx;
			next_words.edx = virt_edx;
		end
		if (hit_gig) begin
			next_words.eax = gig_eax;
			next_words.ebx = gig_ebx;
		end
	end

	// answer register: all four words change together with the valid pulse
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_words <= '0;
		end else begin
			rsp_valid <= req_valid;
			if (req_valid) begin
				rsp_words <= next_words;
			end
		end
	end

	// helper: function of the request being answered
	logic [31:0] func_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			func_q <= 32'h0000_0000;
		end else if (req_valid) begin
			func_q <= req_func;
		end
	end

	// power leaf fixed bits
	property p_pwr_fixed;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_pwr |=> rsp_valid && rsp_words.edx[8:6] == 3'h7
			&& rsp_words.edx[3:0] == 4'h9;
	endproperty
	a_pwr_fixed: assert property (p_pwr_fixed) else $error("power leaf fixed bits wrong");

	// thermal bits follow configuration
	property p_pwr_thermal;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_pwr |=> rsp_words.edx[5:4] == $past({strap.software_thermal_control,
			strap.hardware_thermal_control});
	endproperty
	a_pwr_thermal: assert property (p_pwr_thermal) else $error("thermal bits wrong");

	// linear width follows long mode
	property p_lin_bits;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_addr |=> rsp_words.eax[15:8]
			== ($past(strap.long_mode_capable) ? 8'h30 : 8'h20);
	endproperty
	a_lin_bits: assert property (p_lin_bits) else $error("linear width wrong");

	// physical width and reserved upper half
	property p_phys_bits;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_addr |=> rsp_words.eax[7:0] == 8'h30 && rsp_words.eax[31:16] == 16'h0000;
	endproperty
	a_phys_bits: assert property (p_phys_bits) else $error("physical width wrong");

	// core number width and core count
	property p_core_count;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_addr && strap.core_disable_mask == 4'h0 |=>
			rsp_words.ecx == 32'h0000_2003;
	endproperty
	a_core_count: assert property (p_core_count) else $error("core count word wrong");

	// one disabled core lowers the count by one
	property p_core_down;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_addr && strap.core_disable_mask == 4'h8 |=> rsp_words.ecx[7:0] == 8'h02;
	endproperty
	a_core_down: assert property (p_core_down) else $error("disabled core not counted");

	// virtualization leaf blanked when not capable
	property p_virt_off;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_virt && !strap.virtualization_capable |=> rsp_words == '0;
	endproperty
	a_virt_off: assert property (p_virt_off) else $error("virt leaf not blanked");

	// virtualization leaf contents when capable
	property p_virt_on;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_virt && strap.virtualization_capable |=>
			rsp_words.ebx == 32'h0000_0040 && rsp_words.edx[2:0] == 3'h7
			&& rsp_words.edx[3] == $past(strap.later_revision);
	endproperty
	a_virt_on: assert property (p_virt_on) else $error("virt leaf contents wrong");

	// gig-page l1 geometry
	property p_gig_l1;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_gig |=> rsp_words.eax == 32'hF030_0000;
	endproperty
	a_gig_l1: assert property (p_gig_l1) else $error("gig l1 tlb wrong");

	// gig-page l2 geometry by revision
	property p_gig_l2;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && hit_gig |=> rsp_words.ebx
			== ($past(strap.later_revision) ? 32'h6010_0000 : 32'h0000_0000);
	endproperty
	a_gig_l2: assert property (p_gig_l2) else $error("gig l2 tlb wrong");

	// reserved leaves answer zero
	property p_rsv_leaf;
		@(posedge sys_clk) disable iff (!nrst)
		req_valid && (req_func == `CFI_LEAF_RSV9 || (req_func >= `CFI_LEAF_RSV_LO
			&& req_func <= `CFI_LEAF_RSV_HI)) |=> rsp_words == '0;
	endproperty
	a_rsv_leaf: assert property (p_rsv_leaf) else $error("reserved leaf not zero");

	// words hold steady between answers
	property p_hold;
		@(posedge sys_clk) disable iff (!nrst)
		!req_valid |=> $stable(rsp_words) && !rsp_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without request");

	// answer always tied to the request one cycle back
	property p_answer;
		@(posedge sys_clk) disable iff (!nrst)
		rsp_valid |-> func_q == $past(req_func) && $past(req_valid);
	endproperty
	a_answer: assert property (p_answer) else $error("answer without request");

endmodule
`default_nettype wire

// *** pkg/cfi_cfg.svh ***
// leaf numbers, field positions and fixed field values of the identification responder
`ifndef CFI_CFG_SVH
`define CFI_CFG_SVH

// function numbers served
`define CFI_LEAF_PWR        32'h8000_0007
`define CFI_LEAF_ADDR       32'h8000_0008
`define CFI_LEAF_RSV9       32'h8000_0009
`define CFI_LEAF_VIRT       32'h8000_000A
`define CFI_LEAF_RSV_LO     32'h8000_000B
`define CFI_LEAF_RSV_HI     32'h8000_0018
`define CFI_LEAF_GIG        32'h8000_0019

// power-management edx bit positions
`define CFI_PWR_TS_BIT      0
`define CFI_PWR_FID_BIT     1
`define CFI_PWR_VID_BIT     2
`define CFI_PWR_TTP_BIT     3
`define CFI_PWR_HTC_BIT     4
`define CFI_PWR_STC_BIT     5
`define CFI_PWR_STEP_BIT    6
`define CFI_PWR_HWPS_BIT    7
`define CFI_PWR_TSC_BIT     8

// address-size leaf values
`define CFI_LIN_BITS_LONG   8'h30
`define CFI_LIN_BITS_LEGACY 8'h20
`define CFI_PHYS_BITS       8'h30
`define CFI_CORE_ID_BITS    4'h2
`define CFI_CORE_TOTAL      4
`define CFI_CORE_CNT_W      8

// virtualization leaf values and bit positions
`define CFI_ASID_COUNT      32'h0000_0040
`define CFI_VIRT_NP_BIT     0
`define CFI_VIRT_LBR_BIT    1
`define CFI_VIRT_LOCK_BIT   2
`define CFI_VIRT_NRIP_BIT   3

// large-page tlb geometry
`define CFI_ASSOC_OFF       4'h0
`define CFI_ASSOC_FULL      4'hF
`define CFI_ASSOC_8WAY      4'h6
`define CFI_L1D_GIG_ENTRIES 12'h030
`define CFI_L2D_GIG_ENTRIES 12'h010
`define CFI_NO_ENTRIES      12'h000

`endif

// *** pkg/cfi_pkg.sv ***
// types shared by the identification responder
`default_nettype none
package cfi_pkg;

	// four result words of one leaf
	typedef struct packed {
		logic [31:0] eax;
		logic [31:0] ebx;
		logic [31:0] ecx;
		logic [31:0] edx;
	} cfi_words_type;

	// product configuration seen by the responder
	typedef struct packed {
		logic       long_mode_capable;
		logic       virtualization_capable;
		logic       later_revision;
		logic       software_thermal_control;
		logic       hardware_thermal_control;
		logic [3:0] core_disable_mask;
	} cfi_strap_type;

endpackage
`default_nettype wire

// *** verif/cfi_core_model.sv ***
// requesting core model: presents one function number and captures the answer
`timescale 1ns/100ps
`default_nettype none

module cfi_core_model
	import cfi_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire logic          rsp_valid,
	input  wire cfi_words_type rsp_words,
	output var logic           req_valid,
	output var logic [31:0]    req_func
);
	// idle request lines
	initial begin
		req_valid = 1'b0;
		req_func  = 32'h0000_0000;
	end

	// one-cycle request, then all four words taken in the cycle the answer stands
	task automatic ask(input logic [31:0] func, output cfi_words_type words, output logic ok);
		ok = 1'b0;
		words = '0;
		@(posedge sys_clk);
		#1;
		req_valid = 1'b1;
		req_func  = func;
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		req_func  = 32'h0000_0000;
		// answer must stand right after the taking edge, sampled 1 ns later once settled
		if (rsp_valid === 1'b1) begin
			words = rsp_words;
			ok    = 1'b1;
		end
	endtask
endmodule

`default_nettype wire

// *** verif/tb.sv ***
// testbench: served leaves, reserved-range ends and both outside neighbours under five product configurations, then reset
`timescale 1ns/100ps
`default_nettype none

module tb
	import cfi_pkg::*;
;
	localparam logic [7:0] VREV = 8'h3C; // arbitrary revision code

	logic          sys_clk;
	logic          nrst;
	cfi_strap_type strap;
	wire logic     req_valid;
	wire logic [31:0] req_func;
	logic          rsp_valid;
	cfi_words_type rsp_words;
	cfi_words_type w;
	cfi_words_type e;
	logic          ok;
	int            errors;
	int            compares;
	logic [31:0]   leaves [9] = '{32'h8000_0007, 32'h8000_0008, 32'h8000_0009, 32'h8000_000A,
		32'h8000_000B, 32'h8000_0018, 32'h8000_0019, 32'h8000_0006, 32'h8000_001A};
	cfi_strap_type straps [5] = '{9'h1F0, 9'h005, 9'h1AF, 9'h0D7, 9'h138};

	cfi_leaves #(.VIRT_REVISION(VREV)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
		.req_valid(req_valid), .req_func(req_func), .strap(strap),
		.rsp_valid(rsp_valid), .rsp_words(rsp_words));
	cfi_core_model u_core (.sys_clk(sys_clk), .rsp_valid(rsp_valid), .rsp_words(rsp_words),
		.req_valid(req_valid), .req_func(req_func));

	// clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		errors++;
		close_out();
	end

	// answer words expected for a leaf and configuration
	function automatic cfi_words_type expect_of(logic [31:0] f, cfi_strap_type s);
		cfi_words_type r;
		int on;
		r = '0;
		on = 4 - $countones(s.core_disable_mask);
		case (f)
			32'h8000_0007: r.edx = 32'h0000_01C9 | {26'h0, s.software_thermal_control,
				s.hardware_thermal_control, 4'h0};
			32'h8000_0008: begin
				r.eax = {16'h0, s.long_mode_capable ? 8'h30 : 8'h20, 8'h30};
				r.ecx = {16'h0, 4'h2, 4'h0, (on > 0) ? 8'(on - 1) : 8'h00};
			end
			32'h8000_000A: if (s.virtualization_capable) begin
				r.eax = {24'h0, VREV};
				r.ebx = 32'h0000_0040;
				r.edx = {28'h0, s.later_revision, 3'h7};
			end
			32'h8000_0019: begin
				r.eax = 32'hF030_0000;
				r.ebx = s.later_revision ? 32'h6010_0000 : 32'h0000_0000;
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	// compare and count
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic close_out();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial begin
		nrst = 1'b0;
		strap = 9'h000;
		errors = 0;
		compares = 0;
		repeat (16) @(posedge sys_clk);
		#1 nrst = 1'b1;
		foreach (straps[si]) begin
			@(posedge sys_clk);
			#1 strap = straps[si];
			foreach (leaves[li]) begin
				u_core.ask(leaves[li], w, ok);
				e = expect_of(leaves[li], straps[si]);
				chk("rsp_valid", 32'h1, {31'h0, ok});
				chk("eax", e.eax, w.eax);
				chk("ebx", e.ebx, w.ebx);
				chk("ecx", e.ecx, w.ecx);
				chk("edx", e.edx, w.edx);
				@(posedge sys_clk);
				#1;
				chk("rsp_valid low", 32'h0, {31'h0, rsp_valid});
				chk("words held", 32'h1, {31'h0, rsp_words === w});
			end
		end
		@(posedge sys_clk);
		#1 nrst = 1'b0;
		#1;
		chk("reset valid", 32'h0, {31'h0, rsp_valid});
		chk("reset words", 32'h1, {31'h0, rsp_words === '0});
		// service resumes after a mid-run release; the request is taken at the second edge after it
		@(posedge sys_clk);
		#1 nrst = 1'b1;
		u_core.ask(32'h8000_0008, w, ok);
		e = expect_of(32'h8000_0008, straps[4]);
		chk("valid after reset", 32'h1, {31'h0, ok});
		chk("eax after reset", e.eax, w.eax);
		chk("ecx after reset", e.ecx, w.ecx);
		close_out();
	end
endmodule

`default_nettype wire
